//--- ppc_clk_div.sv
`timescale 1ns/100ps
`default_nettype none
module ppc_clk_div #(
    parameter int unsigned DIV = 2
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic run,
    output logic tick
);

    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_ff;

    if (DIV < 1)
    begin : g_bad_div
        $error("ppc_clk_div: DIV must be at least 1");
    end

    // Counter freezes while stopped, so the phase is kept
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            cnt_ff <= '0;
            tick <= 1'b0;
        end
        else if (!run)
        begin
            tick <= 1'b0;
        end
        else if (cnt_ff == LAST)
        begin
            cnt_ff <= '0;
            tick <= 1'b1;
        end
        else
        begin
            cnt_ff <= cnt_ff + 1'b1;
            tick <= 1'b0;
        end
    end

endmodule : ppc_clk_div
`default_nettype wire

//--- ppc_config_regs.sv
// Our own choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R1: Activation register at index 30h, read/write, resets to 00h.
// R2: Base high byte bits 7-3 read zero; register resets to 02h.
// R3: Software keeps base high bit 2 at zero.
// R4: Base low byte bits 1-0 read zero; register resets to 78h.
// R5: Software keeps base bit 2 zero for EPP in ECP or extended registers.
// R6: Interrupt number and wake enable at 70h, read/write, resets to 07h.
// R7: Interrupt type at 71h: only bit 1 writable, resets to 02h.
// R8: Interrupt type bit 0 reads 1 in Extended mode, else 0.
// R9: Index 75h reads 04h always; index 74h writable, resets to 04h.
// R10: Port configuration at F0h is read/write, resets to F2h.
// R11: Mode 000 compatible, 001 extended, 010 EPP 1.7, 011 EPP 1.9.
// R12: Mode 100 ECP only, 111 ECP with EPP as mode 4; 101, 110 reserved.
// R13: In ECP mode 4, EPP version follows second-level control bit 4.
// R14: Software enables the port and writes C4h at base+2 first.
// R15: Extended access clear: base+403h to 405h ignore writes, reads empty.
// R16: Extended access set: base+403h to 405h respond to reads and writes.
// R17: Power bit clear while active stops port clock; registers kept.
// R18: Power bit set, the default, runs port clock; all modes work. The code also needs the activation bit set to run the clock.
// R19: Float bit set and device inactive puts output pins in high impedance.
// R20: Runtime mode comes from extended control register at base+402h.
// R21: Configuration bits 3-2 ignore writes and read zero.
module ppc_config_regs #(
    parameter int unsigned PORT_CLK_DIV = 2,
    parameter int unsigned SECOND_LVL_DEPTH = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ppc_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ppc_pkg::ppc_rt_req_s rt_req,
    output logic rt_ack,
    output logic rt_hit,
    output logic [7:0] rt_rdata,
    output ppc_pkg::ppc_cfg_s cfg,
    output ppc_pkg::ppc_modes_s modes,
    output logic port_clk_tick,
    output logic pins_float,
    output logic data_out_en
);

    localparam int SLW = $clog2(SECOND_LVL_DEPTH);

    if (SECOND_LVL_DEPTH <= ppc_pkg::CTL2_IDX || SECOND_LVL_DEPTH > 256)
    begin : g_bad_depth
        $error("ppc_config_regs: SECOND_LVL_DEPTH out of range");
    end

    logic [7:0] activate_ff;
    logic [7:0] base_hi_ff;
    logic [7:0] base_lo_ff;
    logic [7:0] irq_num_ff;
    logic [7:0] irq_type_ff;
    logic [7:0] dma_sel_ff;
    logic [7:0] port_cfg_ff;
    logic [7:0] ctrl_ff;
    logic [7:0] ext_ctrl_ff;
    logic [7:0] ext_idx_ff;
    logic [7:0] ext_aux_ff;
    logic [7:0] second_lvl_ff [SECOND_LVL_DEPTH];
    ppc_pkg::ppc_apb_e apb_state_ff;

    logic dev_active;
    logic ext_en;
    logic [15:0] base_addr;
    logic [15:0] rt_ofs;
    logic [7:0] cfg_idx;
    logic idx_ok;
    logic mapped;
    logic [7:0] rd_val;
    logic wr_en;
    logic sl_ok;
    logic sel_ctrl;
    logic sel_ext_ctrl;
    logic sel_idx;
    logic sel_data;
    logic sel_aux;
    logic rt_sel_any;
    logic [7:0] rt_rd_val;
    logic rt_wr;
    ppc_pkg::ppc_modes_s nxt_modes;

    function automatic logic [7:0] masked_write(
        input logic [7:0] old_val,
        input logic [7:0] new_val,
        input logic [7:0] mask
    );
        return (old_val & ~mask) | (new_val & mask);
    endfunction : masked_write

    assign dev_active = activate_ff[ppc_pkg::ACT_BIT];
    assign ext_en = port_cfg_ff[ppc_pkg::CFG_EXT_BIT];
    // Forced-zero bits are never stored, so the base is the raw pair
    assign base_addr = {base_hi_ff, base_lo_ff};
    assign rt_ofs = rt_req.addr - base_addr;
    assign cfg_idx = paddr[ppc_pkg::IDX_LSB +: 8];
    assign idx_ok = (paddr[ppc_pkg::IDX_LSB-1:0] == '0)
        && (paddr[ppc_pkg::APB_AW-1:ppc_pkg::IDX_LSB+8] == '0);
    assign sl_ok = (ext_idx_ff < SECOND_LVL_DEPTH);

    // Register read mux and decode
    always_comb
    begin
        rd_val = '0;
        mapped = idx_ok;
        unique case (cfg_idx)
            // R1: activation readback
            ppc_pkg::IDX_ACTIVATE: rd_val = activate_ff;
            ppc_pkg::IDX_BASE_HI: rd_val = base_hi_ff;
            ppc_pkg::IDX_BASE_LO: rd_val = base_lo_ff;
            ppc_pkg::IDX_IRQ_NUM: rd_val = irq_num_ff;
            // R8: bit 0 tracks the mode
            ppc_pkg::IDX_IRQ_TYPE: rd_val = irq_type_ff | {7'h00, nxt_modes.irq_level};
            ppc_pkg::IDX_DMA_SEL: rd_val = dma_sel_ff;
            // R9: fixed report
            ppc_pkg::IDX_DMA2_RPT: rd_val = ppc_pkg::VAL_DMA2_RPT;
            ppc_pkg::IDX_PORT_CFG: rd_val = port_cfg_ff;
            default: mapped = 1'b0;
        endcase
    end

    // Commit only at the edge where the master sees pready high
    assign wr_en = (apb_state_ff == ppc_pkg::APB_ACK) && psel && penable
        && pwrite && mapped && pstrb[0];

    // APB answer: one wait state on every access
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            apb_state_ff <= ppc_pkg::APB_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else
        begin
            unique case (apb_state_ff)
                ppc_pkg::APB_IDLE:
                begin
                    if (psel && penable)
                    begin
                        apb_state_ff <= ppc_pkg::APB_ACK;
                        pready <= 1'b1;
                        pslverr <= !mapped;
                        prdata <= (pwrite || !mapped) ? '0 : {24'h000000, rd_val};
                    end
                end
                ppc_pkg::APB_ACK:
                begin
                    apb_state_ff <= ppc_pkg::APB_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    // Configuration registers
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            // R1: activation reset
            activate_ff <= ppc_pkg::RST_ACTIVATE;
            // R2: base high reset
            base_hi_ff <= ppc_pkg::RST_BASE_HI;
            // R4: base low reset
            base_lo_ff <= ppc_pkg::RST_BASE_LO;
            // R6: interrupt number reset
            irq_num_ff <= ppc_pkg::RST_IRQ_NUM;
            // R7: interrupt type reset
            irq_type_ff <= ppc_pkg::RST_IRQ_TYPE;
            // R9: DMA select reset
            dma_sel_ff <= ppc_pkg::RST_DMA_SEL;
            // R10: configuration reset
            port_cfg_ff <= ppc_pkg::RST_PORT_CFG;
        end
        else if (wr_en)
        begin
            unique case (cfg_idx)
                ppc_pkg::IDX_ACTIVATE: activate_ff <= pwdata[7:0];
                // R2: upper bits stay zero
                ppc_pkg::IDX_BASE_HI:
                    base_hi_ff <= masked_write(base_hi_ff, pwdata[7:0], ppc_pkg::WM_BASE_HI);
                // R4: low two bits stay zero
                ppc_pkg::IDX_BASE_LO:
                    base_lo_ff <= masked_write(base_lo_ff, pwdata[7:0], ppc_pkg::WM_BASE_LO);
                // R6: full byte write
                ppc_pkg::IDX_IRQ_NUM: irq_num_ff <= pwdata[7:0];
                // R7: only bit 1 stored
                ppc_pkg::IDX_IRQ_TYPE:
                    irq_type_ff <= masked_write(irq_type_ff, pwdata[7:0], ppc_pkg::WM_IRQ_TYPE);
                ppc_pkg::IDX_DMA_SEL: dma_sel_ff <= pwdata[7:0];
                // R21: reserved bits dropped
                ppc_pkg::IDX_PORT_CFG:
                    port_cfg_ff <= masked_write(port_cfg_ff, pwdata[7:0], ppc_pkg::WM_PORT_CFG);
                default: activate_ff <= activate_ff;
            endcase
        end
    end

    // Runtime decode; an inactive device selects no register and reads zero
    always_comb
    begin
        sel_ctrl = 1'b0;
        sel_ext_ctrl = 1'b0;
        sel_idx = 1'b0;
        sel_data = 1'b0;
        sel_aux = 1'b0;
        rt_rd_val = '0;
        if (dev_active)
        begin
            unique case (rt_ofs)
                ppc_pkg::RT_OFS_CTRL:
                begin
                    sel_ctrl = 1'b1;
                    rt_rd_val = ctrl_ff;
                end
                // R20: runtime mode register
                ppc_pkg::RT_OFS_EXT_CTRL:
                begin
                    sel_ext_ctrl = 1'b1;
                    rt_rd_val = ext_ctrl_ff;
                end
                // R15: gated by extended access
                // R16: open when access bit set
                ppc_pkg::RT_OFS_EXT_IDX:
                begin
                    sel_idx = ext_en;
                    rt_rd_val = ext_en ? ext_idx_ff : '0;
                end
                ppc_pkg::RT_OFS_EXT_DATA:
                begin
                    sel_data = ext_en;
                    rt_rd_val = (ext_en && sl_ok) ? second_lvl_ff[ext_idx_ff[SLW-1:0]] : '0;
                end
                ppc_pkg::RT_OFS_EXT_AUX:
                begin
                    sel_aux = ext_en;
                    rt_rd_val = ext_en ? ext_aux_ff : '0;
                end
                default: sel_ctrl = 1'b0;
            endcase
        end
    end

    assign rt_sel_any = sel_ctrl | sel_ext_ctrl | sel_idx | sel_data | sel_aux;
    assign rt_wr = rt_req.req & rt_req.we;

    // Runtime answer one cycle after the request
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            rt_ack <= 1'b0;
            rt_hit <= 1'b0;
            rt_rdata <= '0;
        end
        else
        begin
            rt_ack <= rt_req.req;
            rt_hit <= rt_req.req & rt_sel_any;
            rt_rdata <= (rt_req.req && !rt_req.we) ? rt_rd_val : '0;
        end
    end

    // Runtime registers; kept while the port clock is stopped
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            ctrl_ff <= ppc_pkg::RST_CTRL;
            ext_ctrl_ff <= ppc_pkg::RST_EXT_CTRL;
            ext_idx_ff <= '0;
            ext_aux_ff <= '0;
        end
        else if (rt_wr)
        begin
            if (sel_ctrl)
            begin
                ctrl_ff <= rt_req.wdata;
            end
            if (sel_ext_ctrl)
            begin
                ext_ctrl_ff <= rt_req.wdata;
            end
            // R15: writes dropped when closed
            if (sel_idx)
            begin
                ext_idx_ff <= rt_req.wdata;
            end
            if (sel_aux)
            begin
                ext_aux_ff <= rt_req.wdata;
            end
        end
    end

    // Second-level registers behind the index/data pair
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < SECOND_LVL_DEPTH; i++)
            begin
                second_lvl_ff[i] <= '0;
            end
        end
        // R16: data port reaches the array
        else if (rt_wr && sel_data && sl_ok)
        begin
            second_lvl_ff[ext_idx_ff[SLW-1:0]] <= rt_req.wdata;
        end
    end

    // R11: mode field decode
    // R12: ECP and reserved codes
    // R13: EPP version in mode 4
    ppc_mode_dec ppc_mode_dec_i (
        .cfg_mode(port_cfg_ff[ppc_pkg::CFG_MODE_LSB +: 3]),
        .rt_mode(ext_ctrl_ff[ppc_pkg::EXTC_MODE_LSB +: 3]),
        .ctl2_v19(second_lvl_ff[ppc_pkg::CTL2_IDX][ppc_pkg::CTL2_V19_BIT]),
        .active(dev_active),
        .pwr_on(port_cfg_ff[ppc_pkg::CFG_PWR_BIT]),
        .flags(nxt_modes)
    );

    // R17: clock stops when power bit clear
    // R18: clock runs when power bit set and the device is active
    ppc_clk_div #(
        .DIV(PORT_CLK_DIV)
    ) ppc_clk_div_i (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .run(dev_active & port_cfg_ff[ppc_pkg::CFG_PWR_BIT]),
        .tick(port_clk_tick)
    );

    // Outputs are registered so the pins never glitch on decode
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            cfg <= '0;
            modes <= '0;
            pins_float <= 1'b0;
            data_out_en <= 1'b0;
        end
        else
        begin
            cfg.active <= dev_active;
            cfg.base_addr <= base_addr;
            cfg.irq_num <= irq_num_ff;
            cfg.irq_level_sel <= irq_type_ff[1];
            cfg.dma_chan <= dma_sel_ff;
            modes <= nxt_modes;
            // R19: float only while inactive
            pins_float <= port_cfg_ff[ppc_pkg::CFG_FLOAT_BIT] & !dev_active;
            // R11: compatible mode drives data unless the pins float
            data_out_en <= !(port_cfg_ff[ppc_pkg::CFG_FLOAT_BIT] && !dev_active)
                && !(nxt_modes.data_dir_sw && ctrl_ff[ppc_pkg::CTRL_DIR_BIT]);
        end
    end

endmodule : ppc_config_regs
`default_nettype wire

//--- ppc_config_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ppc_config_regs_checker (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire ppc_pkg::ppc_rt_req_s rt_req,
    input wire logic rt_ack,
    input wire logic rt_hit,
    input wire ppc_pkg::ppc_cfg_s cfg,
    input wire ppc_pkg::ppc_modes_s modes,
    input wire logic port_clk_tick,
    input wire logic pins_float
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    sequence s_acc_first;
        psel && penable && !pready;
    endsequence
    // One wait state, then a single-cycle answer
    sequence s_ack_pulse;
        pready ##1 !pready;
    endsequence

    property p_apb_wait;
        s_acc_first |=> s_ack_pulse;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("apb answer timing wrong");
    property p_err_ack;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err_ack: assert property (p_err_ack) else $error("error without answer");
    property p_rdata_hi;
        pready |-> prdata[31:8] == 24'h0;
    endproperty
    a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
    property p_rt_ack;
        rt_req.req |=> rt_ack;
    endproperty
    a_rt_ack: assert property (p_rt_ack) else $error("runtime ack missing");
    property p_hit_ack;
        rt_hit |-> rt_ack;
    endproperty
    a_hit_ack: assert property (p_hit_ack) else $error("hit without ack");
    property p_irq_type;
        modes.irq_level == (modes.mode == ppc_pkg::MODE_EXTENDED);
    endproperty
    a_irq_type: assert property (p_irq_type) else $error("irq type mismatch");
    // Skew of one cycle tolerated between the two registered copies
    property p_float;
        pins_float && $stable(cfg.active) |-> !cfg.active;
    endproperty
    a_float: assert property (p_float) else $error("float while active");
    property p_clk_stop;
        !cfg.active && !$past(cfg.active) |-> !port_clk_tick;
    endproperty
    a_clk_stop: assert property (p_clk_stop) else $error("tick while inactive");
endmodule : ppc_config_regs_checker

bind ppc_config_regs ppc_config_regs_checker ppc_config_regs_checker_i (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rt_req(rt_req), .rt_ack(rt_ack), .rt_hit(rt_hit),
    .cfg(cfg), .modes(modes), .port_clk_tick(port_clk_tick), .pins_float(pins_float)
);
`default_nettype wire

//--- ppc_mode_dec.sv
`timescale 1ns/100ps
`default_nettype none
module ppc_mode_dec (
    input wire logic [2:0] cfg_mode,
    input wire logic [2:0] rt_mode,
    input wire logic ctl2_v19,
    input wire logic active,
    input wire logic pwr_on,
    output ppc_pkg::ppc_modes_s flags
);

    always_comb
    begin
        flags = '0;
        flags.mode = cfg_mode;
        unique case (cfg_mode)
            ppc_pkg::MODE_COMPAT:
            begin
                flags.data_dir_sw = 1'b0;
            end
            ppc_pkg::MODE_EXTENDED:
            begin
                flags.data_dir_sw = 1'b1;
                flags.irq_level = 1'b1;
            end
            ppc_pkg::MODE_EPP17:
            begin
                flags.epp_on = 1'b1;
            end
            ppc_pkg::MODE_EPP19:
            begin
                flags.epp_on = 1'b1;
                flags.epp_v19 = 1'b1;
            end
            ppc_pkg::MODE_ECP:
            begin
                flags.ecp_on = 1'b1;
                flags.data_dir_sw = 1'b1;
            end
            ppc_pkg::MODE_ECP_EPP:
            begin
                flags.ecp_on = 1'b1;
                flags.data_dir_sw = 1'b1;
                flags.epp_on = (rt_mode == ppc_pkg::EXTC_EPP_MODE);
                flags.epp_v19 = flags.epp_on & ctl2_v19;
            end
            // Reserved codes enable no protocol
            default:
            begin
                flags.data_dir_sw = 1'b0;
            end
        endcase
        // Without the port clock ECP and the EPP timeout cannot run
        flags.ecp_func = flags.ecp_on & active & pwr_on;
        flags.epp_tmo_en = flags.epp_on & active & pwr_on;
    end

endmodule : ppc_mode_dec
`default_nettype wire

//--- ppc_pkg.sv
package ppc_pkg;

    // Configuration indexes; the bus byte address is four times the index
    localparam logic [7:0] IDX_ACTIVATE = 8'h30;
    localparam logic [7:0] IDX_BASE_HI = 8'h60;
    localparam logic [7:0] IDX_BASE_LO = 8'h61;
    localparam logic [7:0] IDX_IRQ_NUM = 8'h70;
    localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
    localparam logic [7:0] IDX_DMA_SEL = 8'h74;
    localparam logic [7:0] IDX_DMA2_RPT = 8'h75;
    localparam logic [7:0] IDX_PORT_CFG = 8'hf0;

    localparam int APB_AW = 12;
    localparam int IDX_LSB = 2;

    // Reset values
    localparam logic [7:0] RST_ACTIVATE = 8'h00;
    localparam logic [7:0] RST_BASE_HI = 8'h02;
    localparam logic [7:0] RST_BASE_LO = 8'h78;
    localparam logic [7:0] RST_IRQ_NUM = 8'h07;
    localparam logic [7:0] RST_IRQ_TYPE = 8'h02;
    localparam logic [7:0] RST_DMA_SEL = 8'h04;
    localparam logic [7:0] VAL_DMA2_RPT = 8'h04;
    localparam logic [7:0] RST_PORT_CFG = 8'hf2;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_EXT_CTRL = 8'h00;

    // Writable bit masks
    localparam logic [7:0] WM_BASE_HI = 8'h07;
    localparam logic [7:0] WM_BASE_LO = 8'hfc;
    localparam logic [7:0] WM_IRQ_TYPE = 8'h02;
    localparam logic [7:0] WM_PORT_CFG = 8'hf3;

    // Field positions
    localparam int ACT_BIT = 0;
    localparam int CFG_MODE_LSB = 5;
    localparam int CFG_EXT_BIT = 4;
    localparam int CFG_PWR_BIT = 1;
    localparam int CFG_FLOAT_BIT = 0;
    localparam int EXTC_MODE_LSB = 5;
    localparam int CTRL_DIR_BIT = 5;
    localparam int CTL2_V19_BIT = 4;
    localparam int CTL2_IDX = 2;

    // Mode codes
    localparam logic [2:0] MODE_COMPAT = 3'h0;
    localparam logic [2:0] MODE_EXTENDED = 3'h1;
    localparam logic [2:0] MODE_EPP17 = 3'h2;
    localparam logic [2:0] MODE_EPP19 = 3'h3;
    localparam logic [2:0] MODE_ECP = 3'h4;
    localparam logic [2:0] MODE_ECP_EPP = 3'h7;
    localparam logic [2:0] EXTC_EPP_MODE = 3'h4;

    // Runtime offsets from the port base address
    localparam logic [15:0] RT_OFS_CTRL = 16'h0002;
    localparam logic [15:0] RT_OFS_EXT_CTRL = 16'h0402;
    localparam logic [15:0] RT_OFS_EXT_IDX = 16'h0403;
    localparam logic [15:0] RT_OFS_EXT_DATA = 16'h0404;
    localparam logic [15:0] RT_OFS_EXT_AUX = 16'h0405;

    typedef enum logic {APB_IDLE, APB_ACK} ppc_apb_e;

    typedef struct packed {
        logic active;
        logic [15:0] base_addr;
        logic [7:0] irq_num;
        logic irq_level_sel;
        logic [7:0] dma_chan;
    } ppc_cfg_s;

    typedef struct packed {
        logic [2:0] mode;
        logic data_dir_sw;
        logic epp_on;
        logic epp_v19;
        logic ecp_on;
        logic ecp_func;
        logic epp_tmo_en;
        logic irq_level;
    } ppc_modes_s;

    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ppc_rt_req_s;

endpackage : ppc_pkg

//--- tb_parallel_port_config_regs.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            err_count++; \
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
        end \
    end
module tb_parallel_port_config_regs;
    localparam logic [15:0] BASE = 16'h0378;
    logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, er, hit;
    logic rt_ack, rt_hit, port_clk_tick, pins_float, data_out_en;
    logic [ppc_pkg::APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, tk;
    logic [7:0] rt_rdata, rtd;
    ppc_pkg::ppc_rt_req_s rt_req;
    ppc_pkg::ppc_cfg_s cfg;
    ppc_pkg::ppc_modes_s modes;
    int err_count, samples_checked;
    logic [7:0] idx_t [8] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h75, 8'hf0};
    logic [7:0] rst_t [8] = '{8'h00, 8'h02, 8'h78, 8'h07, 8'h02, 8'h04, 8'h04, 8'hf2};
    logic [7:0] wb_t [8] = '{8'hff, 8'h07, 8'hfc, 8'hff, 8'h02, 8'hff, 8'h04, 8'hf3};

    ppc_config_regs #(.PORT_CLK_DIV(2), .SECOND_LVL_DEPTH(8)) ppc_config_regs_i (
        .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rt_req(rt_req), .rt_ack(rt_ack), .rt_hit(rt_hit),
        .rt_rdata(rt_rdata), .cfg(cfg), .modes(modes), .port_clk_tick(port_clk_tick),
        .pins_float(pins_float), .data_out_en(data_out_en)
    );

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic complete_run;
        $display("mismatches %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    // Bounded wait: a slave that never answers ends the run
    task automatic apb(input logic we, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= we;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            err_count++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    task automatic rt(input logic we, input logic [15:0] ofs, input logic [7:0] wd);
        int n;
        rt_req <= '{1'b1, we, BASE + ofs, wd};
        @(posedge mclk);
        rt_req.req <= 1'b0;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end while (rt_ack !== 1'b1 && n < 4);
        if (rt_ack !== 1'b1)
        begin
            err_count++;
            complete_run();
        end
        hit = rt_hit;
        rtd = rt_rdata;
    endtask : rt

    task automatic count_ticks;
        tk = 4'h0;
        repeat (8)
        begin
            @(posedge mclk);
            tk = tk + {3'b000, port_clk_tick};
        end
    endtask : count_ticks

    task automatic t_regs;
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b0, idx_t[i], 8'h00);
            `CHK("reset value", rst_t[i], rd[7:0]);
        end
        apb(1'b0, 8'h31, 8'h00);
        `CHK("unmapped error", 1'b1, er);
        for (int i = 0; i < 8; i++)
            apb(1'b1, idx_t[i], 8'hff);
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b0, idx_t[i], 8'h00);
            `CHK("write back", wb_t[i], rd[7:0]);
        end
        `CHK("irq num out", 8'hff, cfg.irq_num);
        `CHK("irq level sel", 1'b1, cfg.irq_level_sel);
        `CHK("dma chan out", 8'hff, cfg.dma_chan);
        pstrb <= 4'he;
        apb(1'b1, 8'h74, 8'h00);
        pstrb <= 4'hf;
        apb(1'b0, 8'h74, 8'h00);
        `CHK("strobe off", 8'hff, rd[7:0]);
    endtask : t_regs

    task automatic t_modes;
        logic [3:0] m;
        // Keep base bits 10 and 2 clear for extended access
        apb(1'b1, 8'h60, 8'h03);
        apb(1'b1, 8'h61, 8'h78);
        rt(1'b1, 16'h0002, 8'hc4);
        `CHK("base out", 16'h0378, cfg.base_addr);
        for (m = 4'h0; m < 4'h8; m++)
        begin
            apb(1'b1, 8'hf0, {m[2:0], 5'b10010});
            apb(1'b0, 8'h71, 8'h00);
            `CHK("irq type", {6'h00, 1'b1, m == 4'h1}, rd[7:0]);
            `CHK("mode", m[2:0], modes.mode);
        end
    endtask : t_modes

    task automatic t_ext;
        apb(1'b1, 8'hf0, 8'he2);
        rt(1'b1, 16'h0403, 8'h02);
        `CHK("gated write hit", 1'b0, hit);
        rt(1'b0, 16'h0403, 8'h00);
        `CHK("gated read data", 8'h00, rtd);
        apb(1'b1, 8'hf0, 8'hf2);
        rt(1'b1, 16'h0403, 8'h02);
        `CHK("open write hit", 1'b1, hit);
        rt(1'b0, 16'h0403, 8'h00);
        `CHK("open read data", 8'h02, rtd);
        rt(1'b1, 16'h0402, 8'h80);
        rt(1'b1, 16'h0404, 8'h10);
        repeat (2) @(posedge mclk);
        `CHK("epp 1.9 on", 1'b1, modes.epp_v19);
        rt(1'b1, 16'h0404, 8'h00);
        repeat (2) @(posedge mclk);
        `CHK("epp 1.9 off", 1'b0, modes.epp_v19);
    endtask : t_ext

    task automatic t_power;
        count_ticks();
        `CHK("ticks running", 4'h4, tk);
        `CHK("ecp func on", 1'b1, modes.ecp_func);
        apb(1'b1, 8'hf0, 8'hf0);
        count_ticks();
        `CHK("ticks stopped", 4'h0, tk);
        `CHK("ecp func off", 1'b0, modes.ecp_func);
        apb(1'b0, 8'h74, 8'h00);
        `CHK("kept register", 8'hff, rd[7:0]);
        apb(1'b1, 8'hf0, 8'hf3);
        apb(1'b1, 8'h30, 8'h00);
        repeat (2) @(posedge mclk);
        `CHK("float on", 1'b1, pins_float);
        `CHK("data drive off", 1'b0, data_out_en);
        apb(1'b1, 8'h30, 8'h01);
        repeat (2) @(posedge mclk);
        `CHK("float off", 1'b0, pins_float);
        `CHK("data drive on", 1'b1, data_out_en);
        // Direction bit set turns the data lines to input
        rt(1'b1, 16'h0002, 8'he4);
        repeat (2) @(posedge mclk);
        `CHK("data input", 1'b0, data_out_en);
    endtask : t_power

    initial
    begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hf;
        rt_req = '0;
        err_count = 0;
        samples_checked = 0;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_regs();
        t_modes();
        t_ext();
        t_power();
        complete_run();
    end
endmodule : tb_parallel_port_config_regs
`default_nettype wire
